// ==== ptlu_top.sv ====
// Position target and limit unit: object dictionary entries for target,
// range limit and software limit, target acceptance and feedback wrap.
// Assumes the master access port is synchronous to sys_clk, one access
// per cycle, and that stored parameters are stable at reset release.
`timescale 1ns/1ps
`include "ptlu_defines.svh"

module ptlu_top (
   // Clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 nrst,
   // Object access from the master
   input  wire logic                 od_req,
   input  wire logic                 od_wr,
   input  wire logic [15:0]          od_index,
   input  wire logic [7:0]           od_sub,
   input  wire logic [31:0]          od_wdata,
   output logic                      od_ack,
   output logic                      od_err,
   output logic [31:0]               od_rdata,
   // Drive context
   input  wire logic [15:0]          control_word,
   input  wire ptlu_pkg::ptlu_drv_t  drive_state,
   input  wire ptlu_pkg::ptlu_mode_t op_mode,
   input  wire logic [15:0]          pos_factor,
   // Stored parameters loaded after reset
   input  wire logic signed [31:0]   stored_range_min,
   input  wire logic signed [31:0]   stored_range_max,
   input  wire logic signed [31:0]   stored_soft_low,
   input  wire logic signed [31:0]   stored_soft_high,
   // Position inputs
   input  wire logic signed [31:0]   fb_pos_raw,
   input  wire logic signed [31:0]   demand_pos,
   // Results
   output logic signed [31:0]        setpoint_ff,
   output logic signed [31:0]        setpoint_inc_ff,
   output logic                      setpoint_valid_ff,
   output logic                      target_refused_ff,
   output logic signed [31:0]        fb_pos_ff,
   output logic                      motion_stop_ff,
   output logic [15:0]               status_word
);

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   logic signed [31:0] target_position_ff;
   logic signed [31:0] range_limit_min_ff;
   logic signed [31:0] range_limit_max_ff;
   logic signed [31:0] soft_limit_min_ff;
   logic signed [31:0] soft_limit_max_ff;
   logic               load_pending_ff;
   logic               od_ack_ff;
   logic               od_err_ff;
   logic [31:0]        od_rdata_ff;
   logic               int_limit_ff;

   // ------------------------------------------------------------
   // Access decode
   // ------------------------------------------------------------
   logic wr_acc;
   logic hit_target;
   logic hit_range;
   logic hit_soft;
   logic sub_ok;
   logic range_locked;

   assign wr_acc     = od_req & od_wr;
   assign hit_target = (od_index == `PTLU_IDX_TARGET) &&
                       (od_sub == `PTLU_SUB_COUNT);
   assign hit_range  = (od_index == `PTLU_IDX_RANGE);
   assign hit_soft   = (od_index == `PTLU_IDX_SOFT);
   assign sub_ok     = (od_sub == `PTLU_SUB_MIN) ||
                       (od_sub == `PTLU_SUB_MAX);
   // Range limits are frozen while the axis may be moving
   assign range_locked = (drive_state == ptlu_pkg::PTLU_ST_ENABLED) ||
                         (drive_state == ptlu_pkg::PTLU_ST_QSTOP);

   // ------------------------------------------------------------
   // Target interpretation and limit check
   // ------------------------------------------------------------
   logic signed [31:0] nxt_target;
   logic signed [31:0] abs_target;
   logic               tgt_below;
   logic               tgt_above;
   logic               act_below;
   logic               act_above;
   logic               dem_below;
   logic               dem_above;
   logic               soft_on;
   logic               tgt_ok;
   logic               mode_uses_target;
   logic               accept_target;

   assign nxt_target = signed'(od_wdata);
   // Relative targets are added to the running set-point
   assign abs_target = control_word[`PTLU_CW_RELATIVE] ?
                       32'(setpoint_ff + nxt_target) :
                       nxt_target;

   // Soft limits are idle when both are zero
   assign soft_on = (soft_limit_min_ff != `PTLU_POS_RESET) ||
                    (soft_limit_max_ff != `PTLU_POS_RESET);

   ptlu_limit_cmp u_cmp_target (
      .lim_min (soft_limit_min_ff),
      .lim_max (soft_limit_max_ff),
      .pos     (abs_target),
      .below   (tgt_below),
      .above   (tgt_above)
   );

   ptlu_limit_cmp u_cmp_actual (
      .lim_min (soft_limit_min_ff),
      .lim_max (soft_limit_max_ff),
      .pos     (fb_pos_ff),
      .below   (act_below),
      .above   (act_above)
   );

   ptlu_limit_cmp u_cmp_demand (
      .lim_min (soft_limit_min_ff),
      .lim_max (soft_limit_max_ff),
      .pos     (demand_pos),
      .below   (dem_below),
      .above   (dem_above)
   );

   // Inside target is fine; outside only if it moves back inward.
   // A target exactly on a limit is allowed, only beyond it is refused.
   always_comb begin
      tgt_ok = 1'b1;
      if (soft_on) begin
         if (abs_target < soft_limit_min_ff) begin
            // Below window: only accept if closer than actual
            tgt_ok = act_below && (abs_target > fb_pos_ff);
         end else if (abs_target > soft_limit_max_ff) begin
            tgt_ok = act_above && (abs_target < fb_pos_ff);
         end
      end
   end

   assign mode_uses_target = (op_mode == ptlu_pkg::PTLU_MODE_PP) ||
                             (op_mode == ptlu_pkg::PTLU_MODE_CSP);
   assign accept_target = wr_acc && hit_target && tgt_ok;

   // ------------------------------------------------------------
   // Target object
   // ------------------------------------------------------------
   // The object always holds what the master wrote, refused or not
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         target_position_ff <= `PTLU_POS_RESET;
      end else if (wr_acc && hit_target) begin
         target_position_ff <= nxt_target;
      end
   end

   // Executing set-point only moves on an accepted target
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         setpoint_ff       <= `PTLU_POS_RESET;
         setpoint_valid_ff <= 1'b0;
      end else begin
         setpoint_valid_ff <= 1'b0;
         if (accept_target && mode_uses_target) begin
            setpoint_ff       <= abs_target;
            setpoint_valid_ff <= 1'b1;
         end
      end
   end

   // Scale to internal increments; product keeps the low word
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         setpoint_inc_ff <= `PTLU_POS_RESET;
      end else begin
         setpoint_inc_ff <= 32'(setpoint_ff *
                                $signed({1'b0, pos_factor}));
      end
   end

   // Refusal flag, a one-cycle pulse per refused target
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         target_refused_ff <= 1'b0;
      end else begin
         target_refused_ff <= wr_acc && hit_target && !tgt_ok;
      end
   end

   // ------------------------------------------------------------
   // Limit objects and power-up loading
   // ------------------------------------------------------------
   // One load cycle after reset release catches the stored values
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         load_pending_ff <= 1'b1;
      end else begin
         load_pending_ff <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         range_limit_min_ff <= `PTLU_POS_RESET;
         range_limit_max_ff <= `PTLU_POS_RESET;
      end else if (load_pending_ff) begin
         range_limit_min_ff <= stored_range_min;
         range_limit_max_ff <= stored_range_max;
      end else if (wr_acc && hit_range && !range_locked) begin
         if (od_sub == `PTLU_SUB_MIN) begin
            range_limit_min_ff <= signed'(od_wdata);
         end else if (od_sub == `PTLU_SUB_MAX) begin
            range_limit_max_ff <= signed'(od_wdata);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         soft_limit_min_ff <= `PTLU_POS_RESET;
         soft_limit_max_ff <= `PTLU_POS_RESET;
      end else if (load_pending_ff) begin
         soft_limit_min_ff <= stored_soft_low;
         soft_limit_max_ff <= stored_soft_high;
      end else if (wr_acc && hit_soft) begin
         if (od_sub == `PTLU_SUB_MIN) begin
            soft_limit_min_ff <= signed'(od_wdata);
         end else if (od_sub == `PTLU_SUB_MAX) begin
            soft_limit_max_ff <= signed'(od_wdata);
         end
      end
   end

   // ------------------------------------------------------------
   // Access answer
   // ------------------------------------------------------------
   // Every request is answered next cycle; errors flag bad access
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         od_ack_ff   <= 1'b0;
         od_err_ff   <= 1'b0;
         od_rdata_ff <= 32'h0000_0000;
      end else begin
         od_ack_ff   <= od_req;
         od_err_ff   <= 1'b0;
         od_rdata_ff <= 32'h0000_0000;
         if (od_req) begin
            if (hit_target) begin
               od_rdata_ff <= target_position_ff;
            end else if (hit_range || hit_soft) begin
               if (od_sub == `PTLU_SUB_COUNT) begin
                  od_rdata_ff <= `PTLU_ENTRY_COUNT;
                  od_err_ff   <= od_wr;  // Count is read only
               end else if (od_sub == `PTLU_SUB_MIN) begin
                  od_rdata_ff <= hit_range ? range_limit_min_ff :
                                             soft_limit_min_ff;
               end else if (od_sub == `PTLU_SUB_MAX) begin
                  od_rdata_ff <= hit_range ? range_limit_max_ff :
                                             soft_limit_max_ff;
               end
               if (od_wr && hit_range && sub_ok && range_locked) begin
                  od_err_ff <= 1'b1;
               end
               if (!sub_ok && od_sub != `PTLU_SUB_COUNT) begin
                  od_err_ff <= 1'b1;
               end
            end else begin
               od_err_ff <= 1'b1;  // Unknown object
            end
         end
      end
   end

   assign od_ack   = od_ack_ff;
   assign od_err   = od_err_ff;
   assign od_rdata = od_rdata_ff;

   // ------------------------------------------------------------
   // Feedback wrap
   // ------------------------------------------------------------
   logic               modulo_on;
   logic signed [32:0] span;
   logic signed [31:0] wrapped;

   // With both limits zero the native 32-bit overflow does the wrap
   assign modulo_on = (range_limit_min_ff != `PTLU_POS_RESET) ||
                      (range_limit_max_ff != `PTLU_POS_RESET);
   assign span = 33'(range_limit_max_ff - range_limit_min_ff);

   // Single fold: feedback moves far less than one span per cycle
   always_comb begin
      wrapped = fb_pos_raw;
      if (modulo_on) begin
         if (fb_pos_raw >= range_limit_max_ff) begin
            wrapped = 32'(fb_pos_raw - span);
         end else if (fb_pos_raw <= range_limit_min_ff) begin
            wrapped = 32'(fb_pos_raw + span);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         fb_pos_ff <= `PTLU_POS_RESET;
      end else begin
         fb_pos_ff <= wrapped;
      end
   end

   // ------------------------------------------------------------
   // Software limit supervision
   // ------------------------------------------------------------
   // Flag while actual or demand sits on or beyond a limit; stop only while actual does
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         int_limit_ff   <= 1'b0;
         motion_stop_ff <= 1'b0;
      end else begin
         int_limit_ff   <= soft_on &&
                           (act_below || act_above ||
                            dem_below || dem_above);
         motion_stop_ff <= soft_on && (act_below || act_above);
      end
   end

   // Only the limit bit is owned here; the rest reads zero
   always_comb begin
      status_word = 16'h0000;
      status_word[`PTLU_SW_INT_LIMIT] = int_limit_ff;
   end

endmodule

// ==== ptlu_defines.svh ====
// Constants for the position target and limit unit: object indices,
// sub-entries, bit positions and reset values.
// Assumes inclusion by bare name from the design files.
`ifndef PTLU_DEFINES_SVH
`define PTLU_DEFINES_SVH

// ---------------------------------------------------------------
// Object indices and sub-entries
// ---------------------------------------------------------------
`define PTLU_IDX_TARGET    16'h607a
`define PTLU_IDX_RANGE     16'h607b
`define PTLU_IDX_SOFT      16'h607d
`define PTLU_SUB_COUNT     8'h00
`define PTLU_SUB_MIN       8'h01
`define PTLU_SUB_MAX       8'h02
`define PTLU_ENTRY_COUNT   32'h0000_0002

// ---------------------------------------------------------------
// Bit positions and reset values
// ---------------------------------------------------------------
`define PTLU_CW_RELATIVE   6
`define PTLU_SW_INT_LIMIT  11
`define PTLU_POS_RESET     32'sh0000_0000

`endif

// ==== ptlu_pkg.sv ====
// Types shared by the position target and limit unit.
// Assumes nothing beyond a SystemVerilog compiler.
package ptlu_pkg;

   // Drive states as seen by this unit
   typedef enum logic [1:0] {
      PTLU_ST_IDLE,
      PTLU_ST_ENABLED,
      PTLU_ST_QSTOP
   } ptlu_drv_t;

   // Operating mode that sources the set-point
   typedef enum logic [1:0] {
      PTLU_MODE_NONE,
      PTLU_MODE_PP,
      PTLU_MODE_CSP
   } ptlu_mode_t;

   typedef logic signed [31:0] ptlu_pos_t;

endpackage

// ==== ptlu_limit_cmp.sv ====
// Window comparator: position against a signed minimum and maximum.
// Assumes min <= max when the window is in use.
`timescale 1ns/1ps

module ptlu_limit_cmp (
   // Window
   input  wire logic signed [31:0] lim_min,
   input  wire logic signed [31:0] lim_max,
   // Position checked
   input  wire logic signed [31:0] pos,
   // Result
   output logic                    below,
   output logic                    above
);

   // Reaching a limit counts as hitting it
   assign below = (pos <= lim_min);
   assign above = (pos >= lim_max);

endmodule

// ==== ptlu_top_sva.sv ====
// Checker for the position target and limit unit, bound to ptlu_top.
// Assumes the registered one-cycle answer of the access port.
`timescale 1ns/1ps

module ptlu_checker (
   // Clock and reset
   input wire logic                 sys_clk,
   input wire logic                 nrst,
   // Access port
   input wire logic                 od_req,
   input wire logic                 od_wr,
   input wire logic [15:0]          od_index,
   input wire logic [7:0]           od_sub,
   input wire logic [31:0]          od_wdata,
   input wire logic                 od_ack,
   input wire logic                 od_err,
   input wire logic [31:0]          od_rdata,
   // Drive context
   input wire logic [15:0]          control_word,
   input wire ptlu_pkg::ptlu_drv_t  drive_state,
   input wire ptlu_pkg::ptlu_mode_t op_mode,
   input wire logic [15:0]          pos_factor,
   // Results
   input wire logic signed [31:0]   setpoint_ff,
   input wire logic signed [31:0]   setpoint_inc_ff,
   input wire logic                 setpoint_valid_ff,
   input wire logic                 target_refused_ff,
   input wire logic                 motion_stop_ff,
   input wire logic [15:0]          status_word
);
   // One domain, so clock and reset are given once
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   ack_follows_req_a:
      assert property (od_req |=> od_ack)
      else $error("access not answered");
   range_lock_a:
      assert property (od_req && od_wr && od_index == 16'h607b
         && (od_sub == 8'h01 || od_sub == 8'h02)
         && drive_state != ptlu_pkg::PTLU_ST_IDLE |=> od_err)
      else $error("locked range write not refused");
   count_read_a:
      assert property (od_req && !od_wr && od_sub == 8'h00
         && (od_index == 16'h607b || od_index == 16'h607d)
         |=> od_ack && !od_err && od_rdata == 32'h0000_0002)
      else $error("entry count wrong");
   abs_target_a:
      assert property (od_req && od_wr && od_index == 16'h607a
         && !control_word[6] ##1 setpoint_valid_ff
         |-> setpoint_ff == $past(od_wdata))
      else $error("absolute target not taken as set-point");
   refuse_keeps_a:
      assert property (target_refused_ff |-> $stable(setpoint_ff))
      else $error("refused target moved set-point");
   mode_gate_a:
      assert property (setpoint_valid_ff
         |-> $past(op_mode) != ptlu_pkg::PTLU_MODE_NONE)
      else $error("set-point updated with no mode");
   inc_scale_a:
      assert property (setpoint_valid_ff |=> setpoint_inc_ff
         == $past(setpoint_ff) * $past(pos_factor))
      else $error("scaled set-point wrong");
   // Bit 11 also rises on a demand-only limit, so a stop implies it
   status_map_a:
      assert property ((status_word & 16'hf7ff) == 16'h0000
         && (!motion_stop_ff || status_word[11]))
      else $error("status word does not mirror limit flag");

   // Main scenarios reached
   cover property (setpoint_valid_ff);
   cover property (target_refused_ff);
   cover property (motion_stop_ff);
endmodule

bind ptlu_top ptlu_checker chk_i (.*);

// ==== ptlu_master_model.sv ====
// Fieldbus master model: one object access at a time.
// Assumes the unit answers one cycle after it takes a request.
`timescale 1ns/1ps

module ptlu_master_model (
   // Clock
   input  wire logic        sys_clk,
   // Access port
   output logic             od_req,
   output logic             od_wr,
   output logic [15:0]      od_index,
   output logic [7:0]       od_sub,
   output logic [31:0]      od_wdata,
   input  wire logic        od_ack,
   input  wire logic        od_err,
   input  wire logic [31:0] od_rdata
);
   initial begin
      od_req   = 1'b0;
      od_wr    = 1'b0;
      od_index = 16'h0000;
      od_sub   = 8'h00;
      od_wdata = 32'h0000_0000;
   end

   // Request lasts one cycle; data is inverted after, so a write that
   // is sampled a cycle late stores ~d and fails its read-back.
   // Locked-state range writes come only when the bench wants a refusal.
   task automatic access(input logic w, input logic [15:0] idx,
         input logic [7:0] sub, input logic [31:0] d,
         output logic [31:0] rd, output logic er, output logic to);
      int i;
      @(posedge sys_clk);
      od_req   <= 1'b1;
      od_wr    <= w;
      od_index <= idx;
      od_sub   <= sub;
      od_wdata <= d;
      @(posedge sys_clk);
      od_req   <= 1'b0;
      od_wdata <= ~d;
      to = 1'b1;
      for (i = 0; i < 4 && to; i++) begin
         @(posedge sys_clk);
         if (od_ack === 1'b1)
            to = 1'b0;
      end
      rd = od_rdata;
      er = od_err;
   endtask
endmodule

// ==== tb_position_target_limit_unit.sv ====
// Bench for the position target and limit unit.
// Assumes the checker and master model files are compiled before it.
`timescale 1ns/1ps

module tb_position_target_limit_unit;
   localparam logic signed [31:0] RMIN = 32'hffff_ff9c;
   localparam logic signed [31:0] RMAX = 32'h0000_0064;
   localparam logic signed [31:0] SLOW = 32'hffff_ffce;
   localparam logic signed [31:0] SHIGH = 32'h0000_0032;
   logic                 sys_clk = 1'b0;
   logic                 nrst, od_req, od_wr, od_ack, od_err;
   logic [15:0]          od_index, control_word, pos_factor, status_word;
   logic [7:0]           od_sub;
   logic [31:0]          od_wdata, od_rdata;
   ptlu_pkg::ptlu_drv_t  drive_state;
   ptlu_pkg::ptlu_mode_t op_mode;
   logic signed [31:0]   stored_range_min, stored_range_max, fb_pos_raw;
   logic signed [31:0]   stored_soft_low, stored_soft_high, demand_pos;
   logic signed [31:0]   setpoint_ff, setpoint_inc_ff, fb_pos_ff;
   logic                 setpoint_valid_ff, target_refused_ff;
   logic                 motion_stop_ff;
   int                   n_mismatch = 0;
   int                   checked = 0;

   ptlu_top uut (.*);
   ptlu_master_model mst (.*);

   always #12.5 sys_clk = ~sys_clk;

   task automatic tally_and_finish();
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chkb(input string what, input logic exp, input logic got);
      chk(what, {31'h0, exp}, {31'h0, got});
   endtask

   // Access, then compare error flag and, on reads, the data
   task automatic acc(input logic w, input logic [15:0] idx,
         input logic [7:0] sub, input logic [31:0] d, input logic ee,
         input logic [31:0] ed);
      logic [31:0] rd;
      logic er, to;
      mst.access(w, idx, sub, d, rd, er, to);
      if (to) begin
         n_mismatch++;
         $display("CHECK FAILED od_ack expected 1 seen 0");
         tally_and_finish();
      end else begin
         chkb("od_err", ee, er);
         if (!w)
            chk("od_rdata", ed, rd);
      end
   endtask

   // Feedback needs two cycles to reach the status; four leave margin
   task automatic feed(input logic [31:0] raw, input logic [31:0] dem);
      fb_pos_raw <= raw;
      demand_pos <= dem;
      repeat (4) @(posedge sys_clk);
   endtask

   initial begin
      nrst = 1'b0;
      control_word = 16'h0000;
      drive_state = ptlu_pkg::PTLU_ST_IDLE;
      op_mode = ptlu_pkg::PTLU_MODE_PP;
      pos_factor = 16'h0003;
      stored_range_min = RMIN;
      stored_range_max = RMAX;
      stored_soft_low = SLOW;
      stored_soft_high = SHIGH;
      fb_pos_raw = 32'h0000_0000;
      demand_pos = 32'h0000_0000;
      repeat (8) @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      acc(0, 16'h607a, 8'h00, 0, 0, 0);
      acc(0, 16'h607b, 8'h00, 0, 0, 2);
      acc(0, 16'h607d, 8'h00, 0, 0, 2);
      acc(0, 16'h607b, 8'h01, 0, 0, RMIN);
      acc(0, 16'h607b, 8'h02, 0, 0, RMAX);
      acc(0, 16'h607d, 8'h01, 0, 0, SLOW);
      acc(0, 16'h607d, 8'h02, 0, 0, SHIGH);
      acc(1, 16'h607d, 8'h00, 5, 1, 0);
      acc(0, 16'h6000, 8'h00, 0, 1, 0);
      $display("test objects done");
      drive_state <= ptlu_pkg::PTLU_ST_ENABLED;
      acc(1, 16'h607b, 8'h01, 7, 1, 0);
      drive_state <= ptlu_pkg::PTLU_ST_QSTOP;
      acc(1, 16'h607b, 8'h02, 7, 1, 0);
      drive_state <= ptlu_pkg::PTLU_ST_IDLE;
      acc(0, 16'h607b, 8'h01, 0, 0, RMIN);
      acc(0, 16'h607b, 8'h02, 0, 0, RMAX);
      $display("test range lock done");
      acc(1, 16'h607a, 8'h00, 32'h14, 0, 0);
      chkb("setpoint_valid_ff", 1, setpoint_valid_ff);
      chk("setpoint_ff", 32'h14, setpoint_ff);
      @(posedge sys_clk);
      chk("setpoint_inc_ff", 32'h14 * 3, setpoint_inc_ff);
      control_word <= 16'h0040;
      op_mode <= ptlu_pkg::PTLU_MODE_CSP;
      acc(1, 16'h607a, 8'h00, 32'h05, 0, 0);
      chk("setpoint_ff", 32'h19, setpoint_ff);
      control_word <= 16'h0000;
      acc(1, 16'h607a, 8'h00, SLOW, 0, 0);
      chk("setpoint_ff", SLOW, setpoint_ff);
      acc(1, 16'h607a, 8'h00, 32'h3c, 0, 0);
      chkb("target_refused_ff", 1, target_refused_ff);
      chk("setpoint_ff", SLOW, setpoint_ff);
      acc(0, 16'h607a, 8'h00, 0, 0, 32'h3c);
      $display("test targets done");
      feed(32'h78, 0);
      chk("fb_pos_ff", 32'h78 - (RMAX - RMIN), fb_pos_ff);
      feed(32'hffff_ff92, 0);
      chk("fb_pos_ff", 32'hffff_ff92 + (RMAX - RMIN), fb_pos_ff);
      chkb("motion_stop_ff", 1, motion_stop_ff);
      chk("status_word", 16'h0800, status_word);
      feed(0, 32'hffff_ffc4);
      chk("status_word", 16'h0800, status_word);
      chkb("motion_stop_ff", 0, motion_stop_ff);
      feed(0, 0);
      chkb("motion_stop_ff", 0, motion_stop_ff);
      chk("status_word", 16'h0000, status_word);
      feed(32'h3c, 0);
      acc(1, 16'h607a, 8'h00, 32'h37, 0, 0);
      chk("setpoint_ff", 32'h37, setpoint_ff);
      acc(1, 16'h607a, 8'h00, 32'h46, 0, 0);
      chkb("target_refused_ff", 1, target_refused_ff);
      feed(32'hffff_ffc4, 0);
      acc(1, 16'h607a, 8'h00, 32'hffff_ffc9, 0, 0);
      chk("setpoint_ff", 32'hffff_ffc9, setpoint_ff);
      acc(1, 16'h607a, 8'h00, 32'hffff_ffba, 0, 0);
      chkb("target_refused_ff", 1, target_refused_ff);
      op_mode <= ptlu_pkg::PTLU_MODE_NONE;
      acc(1, 16'h607a, 8'h00, 32'h10, 0, 0);
      chkb("setpoint_valid_ff", 0, setpoint_valid_ff);
      chk("setpoint_ff", 32'hffff_ffc9, setpoint_ff);
      op_mode <= ptlu_pkg::PTLU_MODE_CSP;
      $display("test feedback done");
      acc(1, 16'h607b, 8'h01, 0, 0, 0);
      acc(1, 16'h607b, 8'h02, 0, 0, 0);
      feed(32'h78, 0);
      chk("fb_pos_ff", 32'h78, fb_pos_ff);
      $display("test modulo off done");
      tally_and_finish();
   end
endmodule
